// [bpd_pkg.sv]
// constants and types for the brushless motor speed drive control
//------------------------------------------------------------------
//------------------------------------------------------------------
package bpd_pkg;
   // clock and timing
   localparam int CLK_KHZ         = 25000;
   localparam int PWM_FREQ_KHZ    = 50;
   localparam int PWM_CYC         = CLK_KHZ / PWM_FREQ_KHZ;
   localparam int LOCK_TIME_US    = 1050000;
   localparam int LOCK_CYC        = LOCK_TIME_US * (CLK_KHZ / 1000);
   localparam int CLK_LOSS_US     = 100000;
   localparam int CLK_LOSS_CYC    = CLK_LOSS_US * (CLK_KHZ / 1000);
   // analog thresholds in millivolts
   localparam logic [12:0] UV_TRIP_MV    = 13'h0e74; // 3700 mV
   localparam logic [12:0] UV_RELEASE_MV = 13'h1068; // 4200 mV
   localparam logic [9:0]  CUR_LIMIT_MV  = 10'h0fa;  // 250 mV
   // duty loop
   localparam int DUTY_W            = 10;
   localparam logic [9:0] DUTY_INIT = 10'h0fa;
   localparam logic [9:0] DUTY_STEP = 10'h004;
   localparam int CNT_W             = 32;
   // synchroniser bit positions
   localparam int S_HALL_AP  = 0;
   localparam int S_HALL_AN  = 1;
   localparam int S_HALL_BP  = 2;
   localparam int S_HALL_BN  = 3;
   localparam int S_HALL_CP  = 4;
   localparam int S_HALL_CN  = 5;
   localparam int S_TACHO    = 6;
   localparam int S_REF      = 7;
   localparam int S_DIVSEL   = 8;
   localparam int S_LOCKNODE = 9;
   localparam int S_BRKSEL   = 10;
   localparam int S_BRAKE    = 11;
   localparam int S_RUN      = 12;
   localparam int S_W        = 13;
   // operating states
   typedef enum logic [2:0] {
      ST_STOP  = 3'b001,
      ST_RUN   = 3'b010,
      ST_BRAKE = 3'b100
   } bpd_state_t;
endpackage

// [bpd_drive_ctrl.sv]
// three-phase brushless drive control with pll speed loop and protection
`timescale 1ns/1ps
module bpd_drive_ctrl
   import bpd_pkg::*;
#(
   parameter int DIV_SEL_LOW  = 1,
   parameter int DIV_SEL_HIGH = 2,
   parameter int LOCK_CYCLES  = LOCK_CYC,
   parameter int LOSS_CYCLES  = CLK_LOSS_CYC,
   parameter int PWM_CYCLES   = PWM_CYC
)(
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   // hall comparator pins
   input  wire logic        hall_a_pos_i,
   input  wire logic        hall_a_neg_i,
   input  wire logic        hall_b_pos_i,
   input  wire logic        hall_b_neg_i,
   input  wire logic        hall_c_pos_i,
   input  wire logic        hall_c_neg_i,
   // speed loop pins
   input  wire logic        tacho_input_pos_i,
   input  wire logic        ref_clk_i,
   input  wire logic        divisor_select_input_i,
   // control and protection pins
   input  wire logic        lock_timer_node_i,
   input  wire logic        brake_style_select_i,
   input  wire logic        brake_i,
   input  wire logic        run_i,
   input  wire logic [12:0] undervoltage_sense_input_i,
   input  wire logic [9:0]  current_sense_node_i,
   // phase drives
   output logic             phase_a_high_drive_o,
   output logic             phase_b_high_drive_o,
   output logic             phase_c_high_drive_o,
   output logic             phase_a_low_drive_o,
   output logic             phase_b_low_drive_o,
   output logic             phase_c_low_drive_o,
   // status
   output logic             speed_pulse_out_o,
   output logic             lock_fault_o,
   output logic             uv_fault_o,
   output logic             clk_lost_o
);
   //---------------------------------------------------------------
   // input synchronisers
   //---------------------------------------------------------------
   logic [S_W-1:0] pin_raw;
   logic [S_W-1:0] sync1;
   logic [S_W-1:0] pin_s;
   logic [12:0]    uv1;
   logic [12:0]    uv_s;
   logic [9:0]     cur1;
   logic [9:0]     cur_s;
   assign pin_raw = {run_i, brake_i, brake_style_select_i, lock_timer_node_i,
                     divisor_select_input_i, ref_clk_i, tacho_input_pos_i,
                     hall_c_neg_i, hall_c_pos_i, hall_b_neg_i, hall_b_pos_i,
                     hall_a_neg_i, hall_a_pos_i};
   // two flops per pin bit
   genvar gi;
   generate
      for (gi = 0; gi < S_W; gi++)
      begin : g_sync
         always_ff @(posedge sys_clk_i)
         begin
            if (!rst_b_i)
            begin
               sync1[gi] <= 1'b0;
               pin_s[gi] <= 1'b0;
            end
            else
            begin
               sync1[gi] <= pin_raw[gi];
               pin_s[gi] <= sync1[gi];
            end
         end
      end
   endgenerate
   // sense codes are slow analog readings, settled before use
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
      begin
         uv1   <= 13'h0000;
         uv_s  <= 13'h0000;
         cur1  <= 10'h000;
         cur_s <= 10'h000;
      end
      else
      begin
         uv1   <= undervoltage_sense_input_i;
         uv_s  <= uv1;
         cur1  <= current_sense_node_i;
         cur_s <= cur1;
      end
   end
   // grounded lock timer node holds the logic in reset
   logic lrst;
   assign lrst = !rst_b_i || !pin_s[S_LOCKNODE];
   //---------------------------------------------------------------
   // hall decode and edge detect
   //---------------------------------------------------------------
   logic [2:0] hall;
   logic       tacho_d;
   logic       ref_d;
   logic       tacho_fall;
   logic       ref_fall;
   // equal inputs keep the last decided level
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst)
         hall <= 3'h0;
      else
      begin
         if (pin_s[S_HALL_AP] != pin_s[S_HALL_AN])
            hall[0] <= pin_s[S_HALL_AP];
         if (pin_s[S_HALL_BP] != pin_s[S_HALL_BN])
            hall[1] <= pin_s[S_HALL_BP];
         if (pin_s[S_HALL_CP] != pin_s[S_HALL_CN])
            hall[2] <= pin_s[S_HALL_CP];
      end
   end
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst)
      begin
         tacho_d <= 1'b0;
         ref_d   <= 1'b0;
      end
      else
      begin
         tacho_d <= pin_s[S_TACHO];
         ref_d   <= pin_s[S_REF];
      end
   end
   assign tacho_fall = tacho_d && !pin_s[S_TACHO];
   assign ref_fall   = ref_d && !pin_s[S_REF];
   //---------------------------------------------------------------
   // operating state
   //---------------------------------------------------------------
   bpd_state_t st;
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst)
         st <= ST_STOP;
      else if (pin_s[S_BRAKE])
         st <= ST_BRAKE;
      else if (pin_s[S_RUN])
         st <= ST_RUN;
      else
         st <= ST_STOP;
   end
   //---------------------------------------------------------------
   // reference divider and phase detector
   //---------------------------------------------------------------
   logic [7:0]        div_cnt;
   logic [7:0]        div_n;
   logic              ref_ev;
   logic              fb_since_ref;
   logic              ref_since_fb;
   logic              decel;
   logic [DUTY_W-1:0] duty;
   assign div_n  = pin_s[S_DIVSEL] ? 8'(DIV_SEL_HIGH) : 8'(DIV_SEL_LOW);
   assign ref_ev = ref_fall && (div_cnt == div_n - 8'h01);
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst || st != ST_RUN)
         div_cnt <= 8'h00;
      else if (ref_fall)
         div_cnt <= (div_cnt == div_n - 8'h01) ? 8'h00 : div_cnt + 8'h01;
   end
   // bang-bang loop: late feedback raises duty, early feedback lowers it
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst || st != ST_RUN)
      begin
         fb_since_ref <= 1'b0;
         ref_since_fb <= 1'b0;
         decel        <= 1'b0;
         duty         <= DUTY_INIT;
      end
      else if (ref_ev && !tacho_fall)
      begin
         ref_since_fb <= 1'b1;
         fb_since_ref <= 1'b0;
         if (!fb_since_ref)
         begin
            decel <= 1'b0;
            if (duty <= DUTY_W'(PWM_CYCLES) - DUTY_STEP)
               duty <= duty + DUTY_STEP;
         end
      end
      else if (tacho_fall && !ref_ev)
      begin
         fb_since_ref <= 1'b1;
         ref_since_fb <= 1'b0;
         if (!ref_since_fb)
         begin
            decel <= 1'b1;
            if (duty >= DUTY_STEP)
               duty <= duty - DUTY_STEP;
         end
      end
   end
   //---------------------------------------------------------------
   // protection: clock loss, locked rotor, undervoltage
   //---------------------------------------------------------------
   logic [CNT_W-1:0] loss_cnt;
   logic [CNT_W-1:0] lock_cnt;
   logic [2:0]       hall_d;
   logic             lock_fault;
   logic             uv_fault;
   logic             clk_lost;
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst || st != ST_RUN || ref_fall)
      begin
         loss_cnt <= '0;
         clk_lost <= 1'b0;
      end
      else if (loss_cnt >= CNT_W'(LOSS_CYCLES - 1))
         clk_lost <= 1'b1;
      else
         loss_cnt <= loss_cnt + 1'b1;
   end
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst)
         hall_d <= 3'h0;
      else
         hall_d <= hall;
   end
   // counter restarts on each hall change and is cleared while decelerating
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst || st != ST_RUN || hall != hall_d || decel)
         lock_cnt <= '0;
      else if (lock_cnt < CNT_W'(LOCK_CYCLES))
         lock_cnt <= lock_cnt + 1'b1;
   end
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst || st == ST_STOP)
         lock_fault <= 1'b0;
      else if (lock_cnt >= CNT_W'(LOCK_CYCLES))
         lock_fault <= 1'b1;
   end
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst)
         uv_fault <= 1'b0;
      else if (uv_s < UV_TRIP_MV)
         uv_fault <= 1'b1;
      else if (uv_s > UV_RELEASE_MV)
         uv_fault <= 1'b0;
   end
   //---------------------------------------------------------------
   // pwm timebase and current limit chop
   //---------------------------------------------------------------
   logic [DUTY_W-1:0] pwm_cnt;
   logic              cl_chop;
   logic              over_lim;
   assign over_lim = (cur_s >= CUR_LIMIT_MV) && st != ST_BRAKE;
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst || pwm_cnt == DUTY_W'(PWM_CYCLES - 1))
         pwm_cnt <= '0;
      else
         pwm_cnt <= pwm_cnt + 1'b1;
   end
   // set wins over the period-start clear
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst)
         cl_chop <= 1'b0;
      else if (over_lim)
         cl_chop <= 1'b1;
      else if (pwm_cnt == '0)
         cl_chop <= 1'b0;
   end
   //---------------------------------------------------------------
   // commutation and output drive
   //---------------------------------------------------------------
   logic [2:0] pat_hi;
   logic [2:0] pat_lo;
   logic [2:0] next_hi;
   logic [2:0] next_lo;
   logic [2:0] drv_hi;
   logic [2:0] drv_lo;
   logic       pwm_on;
   // six-step table, bit 0 is phase a
   always_comb
   begin
      case (hall)
         3'h1:    begin pat_hi = 3'h1; pat_lo = 3'h2; end
         3'h3:    begin pat_hi = 3'h1; pat_lo = 3'h4; end
         3'h2:    begin pat_hi = 3'h2; pat_lo = 3'h4; end
         3'h6:    begin pat_hi = 3'h2; pat_lo = 3'h1; end
         3'h4:    begin pat_hi = 3'h4; pat_lo = 3'h1; end
         3'h5:    begin pat_hi = 3'h4; pat_lo = 3'h2; end
         default: begin pat_hi = 3'h0; pat_lo = 3'h0; end
      endcase
   end
   assign pwm_on = (pwm_cnt < duty) && !cl_chop;
   always_comb
   begin
      next_hi = 3'h0;
      next_lo = 3'h0;
      case (st)
         ST_BRAKE:
            if (pin_s[S_BRKSEL])
               next_hi = 3'h7;
         ST_RUN:
         begin
            next_lo = pat_lo;
            if (!(lock_fault || uv_fault || clk_lost) && pwm_on)
               next_hi = pat_hi;
         end
         default:
         begin
            next_hi = 3'h0;
            next_lo = 3'h0;
         end
      endcase
   end
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst)
      begin
         drv_hi            <= 3'h0;
         drv_lo            <= 3'h0;
         speed_pulse_out_o <= 1'b0;
         lock_fault_o      <= 1'b0;
         uv_fault_o        <= 1'b0;
         clk_lost_o        <= 1'b0;
      end
      else
      begin
         drv_hi            <= next_hi;
         drv_lo            <= next_lo;
         speed_pulse_out_o <= pin_s[S_TACHO];
         lock_fault_o      <= lock_fault;
         uv_fault_o        <= uv_fault;
         clk_lost_o        <= clk_lost;
      end
   end
   assign {phase_c_high_drive_o, phase_b_high_drive_o,
           phase_a_high_drive_o} = drv_hi;
   assign {phase_c_low_drive_o, phase_b_low_drive_o,
           phase_a_low_drive_o} = drv_lo;
   //---------------------------------------------------------------
   // assertions
   //---------------------------------------------------------------
   sequence brake_short_s;
      st == ST_BRAKE && pin_s[S_BRKSEL];
   endsequence
   sequence drive_short_s;
      drv_hi == 3'h7 && drv_lo == 3'h0;
   endsequence
   // limit seen in run, and still in run while the chop is applied
   sequence chop_in_run_s;
      over_lim && st == ST_RUN ##1 st == ST_RUN;
   endsequence
   phase_overlap_a: assert property (@(posedge sys_clk_i) disable iff (lrst)
      st == ST_RUN |=> (drv_hi & drv_lo) == 3'h0 && $onehot0(drv_lo))
      else $error("high and low drive overlap on one phase");
   short_brake_a: assert property (@(posedge sys_clk_i) disable iff (lrst)
      brake_short_s |=> drive_short_s)
      else $error("short brake pattern not driven");
   stop_idle_a: assert property (@(posedge sys_clk_i) disable iff (lrst)
      st == ST_STOP |=> drv_hi == 3'h0 && drv_lo == 3'h0 && duty == DUTY_INIT)
      else $error("outputs active in stop state");
   lock_latch_a: assert property (@(posedge sys_clk_i) disable iff (lrst)
      lock_fault && !pin_s[S_BRAKE] && pin_s[S_RUN] && st != ST_STOP
      |=> lock_fault)
      else $error("locked-rotor latch released early");
   lock_off_a: assert property (@(posedge sys_clk_i) disable iff (lrst)
      lock_fault && st == ST_RUN |=> drv_hi == 3'h0)
      else $error("high side on during locked-rotor shutoff");
   uv_trip_a: assert property (@(posedge sys_clk_i) disable iff (lrst)
      uv_s < UV_TRIP_MV |=> uv_fault ##1 (st != ST_RUN || drv_hi == 3'h0))
      else $error("undervoltage did not shut high side");
   uv_hold_a: assert property (@(posedge sys_clk_i) disable iff (lrst)
      uv_fault && uv_s <= UV_RELEASE_MV |=> uv_fault)
      else $error("undervoltage released below release level");
   node_reset_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !pin_s[S_LOCKNODE] |=> st == ST_STOP && drv_hi == 3'h0)
      else $error("logic not held in reset by lock node");
   cur_chop_a: assert property (@(posedge sys_clk_i) disable iff (lrst)
      chop_in_run_s |=> drv_hi == 3'h0)
      else $error("current limit did not cut duty");
   brake_nochop_a: assert property (@(posedge sys_clk_i) disable iff (lrst)
      st == ST_BRAKE && pin_s[S_BRKSEL] && $past(st) == ST_BRAKE
      |=> drv_hi == 3'h7)
      else $error("current limit acted during braking");
   duty_up_a: assert property (@(posedge sys_clk_i) disable iff (lrst)
      st == ST_RUN && pin_s[S_RUN] && !pin_s[S_BRAKE] && ref_ev
      && !tacho_fall && !fb_since_ref
      && duty <= DUTY_W'(PWM_CYCLES) - DUTY_STEP
      |=> duty == $past(duty) + DUTY_STEP && !decel)
      else $error("late feedback did not raise duty");
endmodule

// [bpd_motor_model.sv]
// motor model: rotor position seen as hall pin pairs and a tacho line
`timescale 1ns/1ps
module bpd_motor_model (
   // clock
   input  wire logic       sys_clk_i,
   // rotor control from the bench
   input  wire logic       load_i,
   input  wire logic [2:0] code_i,
   input  wire logic [7:0] step_cyc_i,
   // low-side drives feeding the coils
   input  wire logic [2:0] low_drive_i,
   // sensor pins
   output logic      [2:0] hall_pos_o,
   output logic      [2:0] hall_neg_o,
   output logic            tacho_o
);
   logic [2:0] pos;
   logic [7:0] cnt;

   //------------------------------------------------------------
   // rotor motion
   //------------------------------------------------------------
   // one six-step position per step_cyc_i+1 clocks while a coil is fed;
   // a stalled rotor (step 0) holds its hall code indefinitely
   always_ff @(posedge sys_clk_i)
   begin
      if (load_i)
      begin
         pos <= code_i;
         cnt <= 8'h00;
      end
      else if (step_cyc_i != 8'h00 && low_drive_i != 3'h0)
      begin
         cnt <= cnt + 8'h01;
         if (cnt >= step_cyc_i)
         begin
            cnt <= 8'h00;
            case (pos)
               3'h1:    pos <= 3'h3;
               3'h3:    pos <= 3'h2;
               3'h2:    pos <= 3'h6;
               3'h6:    pos <= 3'h4;
               3'h4:    pos <= 3'h5;
               default: pos <= 3'h1;
            endcase
         end
      end
   end

   // sensor pair: positive side above negative side reads as high
   assign hall_pos_o = pos;
   assign hall_neg_o = ~pos;
   assign tacho_o    = pos[0];
endmodule

// [testbench.sv]
// self-checking bench for the brushless drive control
`timescale 1ns/1ps
module testbench;
   import bpd_pkg::*;
   localparam int LOCK_N = 200;
   localparam int LOSS_N = 300;
   localparam int PWM_N  = 40;
   localparam logic [12:0] UV_TAB [7] = '{13'h0e73, 13'h0fa0, 13'h1068,
      13'h1069, 13'h0e74, 13'h0e73, 13'h1388};
   logic        clk       = 1'b0;
   logic        rst_b     = 1'b0;
   logic        ref_clk   = 1'b1;
   logic        div_sel   = 1'b0;
   logic        lock_node = 1'b1;
   logic        brk_sel   = 1'b0;
   logic        brake     = 1'b0;
   logic        run       = 1'b0;
   logic [12:0] uv        = 13'h1388;
   logic [9:0]  cur       = 10'h000;
   logic        load      = 1'b1;
   logic [2:0]  code      = 3'h1;
   logic [7:0]  step      = 8'h00;
   logic        ref_on    = 1'b0;
   int          ref_half  = 10;
   int          ref_cnt   = 0;
   int          cycles    = 0;
   int          err_total = 0;
   int          checked   = 0;
   logic [2:0]  hp;
   logic [2:0]  hn;
   logic [2:0]  hi;
   logic [2:0]  lo;
   logic        tacho;
   logic        spd;
   logic        lock_f;
   logic        uv_f;
   logic        lost;

   bpd_drive_ctrl #(.LOCK_CYCLES(LOCK_N), .LOSS_CYCLES(LOSS_N),
      .PWM_CYCLES(PWM_N)) uut (
      .sys_clk_i(clk), .rst_b_i(rst_b),
      .hall_a_pos_i(hp[0]), .hall_a_neg_i(hn[0]),
      .hall_b_pos_i(hp[1]), .hall_b_neg_i(hn[1]),
      .hall_c_pos_i(hp[2]), .hall_c_neg_i(hn[2]),
      .tacho_input_pos_i(tacho), .ref_clk_i(ref_clk),
      .divisor_select_input_i(div_sel), .lock_timer_node_i(lock_node),
      .brake_style_select_i(brk_sel), .brake_i(brake), .run_i(run),
      .undervoltage_sense_input_i(uv), .current_sense_node_i(cur),
      .phase_a_high_drive_o(hi[0]), .phase_b_high_drive_o(hi[1]),
      .phase_c_high_drive_o(hi[2]), .phase_a_low_drive_o(lo[0]),
      .phase_b_low_drive_o(lo[1]), .phase_c_low_drive_o(lo[2]),
      .speed_pulse_out_o(spd), .lock_fault_o(lock_f),
      .uv_fault_o(uv_f), .clk_lost_o(lost));

   bpd_motor_model motor (
      .sys_clk_i(clk), .load_i(load), .code_i(code), .step_cyc_i(step),
      .low_drive_i(lo), .hall_pos_o(hp), .hall_neg_o(hn), .tacho_o(tacho));

   //------------------------------------------------------------
   // clocks and watchdog
   //------------------------------------------------------------
   // system clock, 40 ns period
   always #20 clk = ~clk;

   // reference clock, stands still while ref_on is low
   always @(posedge clk)
   begin
      if (ref_on)
      begin
         ref_cnt <= (ref_cnt >= ref_half - 1) ? 0 : ref_cnt + 1;
         if (ref_cnt >= ref_half - 1)
            ref_clk <= ~ref_clk;
      end
   end

   // hang guard well above the expected run length
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         err_total++;
         give_verdict();
      end
   end

   //------------------------------------------------------------
   // helpers
   //------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // put the rotor at a given hall code
   task automatic ld(input logic [2:0] c);
      @(posedge clk);
      load <= 1'b1;
      code <= c;
      @(posedge clk);
      load <= 1'b0;
   endtask

   // pass through stop so duty and the lock and clock-loss faults start afresh
   task automatic restart();
      run <= 1'b0;
      tick(6);
      run <= 1'b1;
      tick(6);
   endtask

   // count high-side on clocks over one pwm period
   task automatic duty_cnt(output int on);
      on = 0;
      repeat (PWM_N)
      begin
         @(posedge clk);
         if (hi !== 3'h0)
            on++;
      end
   endtask

   // expected {high, low} for a hall code
   function automatic logic [5:0] pat(input logic [2:0] c);
      case (c)
         3'h1:    pat = 6'h0a;
         3'h3:    pat = 6'h0c;
         3'h2:    pat = 6'h14;
         3'h6:    pat = 6'h11;
         3'h4:    pat = 6'h21;
         3'h5:    pat = 6'h22;
         default: pat = 6'h00;
      endcase
   endfunction

   // undervoltage latch with hysteresis
   function automatic logic uv_next(input logic prev, input logic [12:0] mv);
      if (mv < UV_TRIP_MV)
         uv_next = 1'b1;
      else if (mv > UV_RELEASE_MV)
         uv_next = 1'b0;
      else
         uv_next = prev;
   endfunction

   //------------------------------------------------------------
   // main sequence
   //------------------------------------------------------------
   initial
   begin
      int         on;
      int         i;
      logic [2:0] c;
      logic       exp_uv;
      void'($urandom(32'h799e));
      exp_uv = 1'b0;
      tick(5);
      chk({hi, lo, spd, lock_f}, 8'h00, "outputs in reset");
      // package chopping rate must sit in the 30 to 100 kHz band
      chk({7'h0, CLK_KHZ / PWM_CYC inside {[30:100]}}, 8'h01, "pwm");
      tick(1);
      rst_b     <= 1'b1;
      load      <= 1'b0;
      run       <= 1'b1;
      lock_node <= 1'b0;
      tick(8);
      chk({2'h0, hi, lo}, 8'h00, "timer node grounded");
      lock_node <= 1'b1;
      tick(8);
      // all hall codes, then random ones
      for (i = 0; i < 20; i++)
      begin
         c = (i < 8) ? i[2:0] : 3'($urandom());
         ld(c);
         tick(6);
         chk({1'b0, hi, lo, spd}, {1'b0, pat(c), c[0]}, "commutation");
      end
      run <= 1'b0;
      tick(6);
      chk({hi, lo, lock_f, lost}, 8'h00, "stop state");
      // current limit and braking
      ref_on <= 1'b1;
      restart();
      ld(3'h1);
      tick(8);
      cur <= 10'h0fa;
      tick(6);
      chk({2'h0, hi, lo}, 8'h02, "current at limit");
      cur <= 10'h0f9;
      tick(50);
      chk({2'h0, hi, lo}, 8'h0a, "current below limit");
      cur     <= 10'h12c;
      brake   <= 1'b1;
      brk_sel <= 1'b1;
      tick(6);
      chk({2'h0, hi, lo}, 8'h38, "short brake");
      brk_sel <= 1'b0;
      tick(6);
      chk({2'h0, hi, lo}, 8'h00, "free run brake");
      brake <= 1'b0;
      cur   <= 10'h000;
      // undervoltage hysteresis, hall kept moving
      restart();
      for (i = 0; i < 7; i++)
      begin
         uv <= UV_TAB[i];
         exp_uv = uv_next(exp_uv, UV_TAB[i]);
         ld(i[0] ? 3'h3 : 3'h1);
         tick(6);
         chk({4'h0, uv_f, hi}, {4'h0, exp_uv, exp_uv ? 3'h0 : 3'h1},
             "undervoltage");
      end
      // speed loop: stalled rotor runs full duty, fast tacho cuts it
      restart();
      tick(10);
      duty_cnt(on);
      chk(8'(on), 8'(PWM_N), "full duty when stalled");
      ref_half <= 100;
      div_sel  <= 1'b1;
      step     <= 8'h01;
      tick(800);
      duty_cnt(on);
      chk({7'h0, on < 20}, 8'h01, "duty cut when tacho leads");
      // reference clock lost while turning
      ref_on <= 1'b0;
      tick(LOSS_N + 20);
      chk({5'h0, lost, hi == 3'h0, lo != 3'h0}, 8'h07, "reference lost");
      ref_on   <= 1'b1;
      ref_half <= 10;
      tick(30);
      chk({7'h0, lost}, 8'h00, "reference back");
      // stalled rotor with reference running: duty climbs back up
      step <= 8'h00;
      tick(120);
      duty_cnt(on);
      chk({7'h0, on > 2}, 8'h01, "duty rises when tacho lags");
      // locked rotor: masked while slowing, then latched
      step   <= 8'h00;
      ref_on <= 1'b0;
      restart();
      ld(3'h1);
      tick(4);
      ld(3'h2);
      tick(LOCK_N + 20);
      chk({7'h0, lock_f}, 8'h00, "no lock while slowing");
      ref_on <= 1'b1;
      tick(LOCK_N + 100);
      chk({6'h0, lock_f, hi == 3'h0}, 8'h03, "locked rotor");
      ld(3'h6);
      tick(10);
      chk({7'h0, lock_f}, 8'h01, "fault stays latched");
      run <= 1'b0;
      tick(6);
      chk({hi, lo, lock_f, lost}, 8'h00, "stop clears fault");
      run <= 1'b1;
      tick(8);
      chk({7'h0, lock_f}, 8'h00, "restart without fault");
      give_verdict();
   end
endmodule
